// File: bcl_map.vh
// register map constants for the bridge command low byte block
// assumes an axi4-lite slave with 32-bit data and word-aligned registers
// Overview of operation
// RULE1: stepping enable bit 7 is hardwired zero; no stepping is ever done
// RULE2: parity response enable bit 6 always reads zero
// RULE3: memory write and invalidate bit 4 reads zero, writes ignored
// RULE4: special cycle enable bit 3 reads zero, writes ignored
// RULE5: master enable clear (reset) ignores all secondary frame cycles
// RULE6: master enable set accepts frame cycles only on a decode hit
// RULE7: master enable never gates sideband or pipe queued requests
// RULE8: memory window enable clear decodes no memory space
// RULE9: memory enable set decodes memory, prefetch and legacy vga windows
// RULE10: io window enable clear decodes no io space
// RULE11: io enable set decodes range between io base and io limit
// RULE12: reserved bit 5 reads zero and writes have no effect
`ifndef BCL_MAP_VH
`define BCL_MAP_VH
`define BCL_OFF_CMD 12'h004
`define BCL_OFF_MEMWIN 12'h020
`define BCL_OFF_PBASE 12'h024
`define BCL_OFF_IOWIN 12'h01c
`define BCL_OFF_STAT 12'h040
`define BCL_BIT_IO 0
`define BCL_BIT_MEM 1
`define BCL_BIT_MST 2
`define BCL_CMD_RST 3'h0
`define BCL_IO_BASE_RST 8'hf0
`define BCL_IOLIM_RST 8'h00
`define BCL_MEMBASE_RST 16'hfff0
`define BCL_MLIM_RST 16'h0000
`define BCL_RESP_OK 2'h0
`define BCL_RESP_ERR 2'h2
`define BCL_VGA_LO 32'h000a0000
`define BCL_VGA_HI 32'h000bffff
`endif

// File: bcl_win.v
// one inclusive address window compare, gated by its enable
// assumes base and limit already expanded to full byte addresses
`timescale 1ns/1ps
`default_nettype none
module bcl_win #(
    parameter AW = 32
) (
    input wire en_in,
    input wire [AW-1:0] addr_in,
    input wire [AW-1:0] lo_in,
    input wire [AW-1:0] hi_in,
    output wire hit_out
);
    // limit below base gives an empty window, as software expects
    assign hit_out = en_in && (addr_in >= lo_in) && (addr_in <= hi_in);
endmodule
`default_nettype wire

// File: bcl_decode.v
// window decoder: memory, prefetch, vga and io ranges
// assumes window registers held in bridge header format
`timescale 1ns/1ps
`default_nettype none
module bcl_decode (
    input wire mem_en_in,
    input wire io_en_in,
    input wire [31:0] addr_in,
    input wire is_io_in,
    input wire [15:0] mem_base_in,
    input wire [15:0] mem_limit_in,
    input wire [15:0] pbase_in,
    input wire [15:0] plimit_in,
    input wire [7:0] io_base_in,
    input wire [7:0] io_limit_in,
    output wire hit_out
);
    `include "bcl_map.vh"
    wire [3:0] hits;
    wire mem_q;
    wire io_q;
    assign mem_q = mem_en_in && !is_io_in; // RULE8
    assign io_q = io_en_in && is_io_in; // RULE10
    // memory windows are 1 MiB granular, io windows 4 KiB in 64 KiB space
    bcl_win u_mem (
        .en_in(mem_q),
        .addr_in(addr_in),
        .lo_in({mem_base_in[15:4], 20'h00000}),
        .hi_in({mem_limit_in[15:4], 20'hfffff}),
        .hit_out(hits[0])
    ); // RULE9
    bcl_win u_pre (
        .en_in(mem_q),
        .addr_in(addr_in),
        .lo_in({pbase_in[15:4], 20'h00000}),
        .hi_in({plimit_in[15:4], 20'hfffff}),
        .hit_out(hits[1])
    ); // RULE9
    bcl_win u_vga (
        .en_in(mem_q),
        .addr_in(addr_in),
        .lo_in(`BCL_VGA_LO),
        .hi_in(`BCL_VGA_HI),
        .hit_out(hits[2])
    ); // RULE9
    bcl_win u_io (
        .en_in(io_q),
        .addr_in(addr_in),
        .lo_in({16'h0000, io_base_in[7:4], 12'h000}),
        .hi_in({16'h0000, io_limit_in[7:4], 12'hfff}),
        .hit_out(hits[3])
    ); // RULE11
    assign hit_out = |hits;
endmodule
`default_nettype wire

// File: bcl_top.v
// bridge command low byte: axi4-lite registers and secondary cycle gating
// assumes one outstanding write and read per axi4-lite rules
`timescale 1ns/1ps
`default_nettype none
module bcl_top (
    input wire clk_in,
    input wire srst_in,
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire frame_req_in,
    input wire [31:0] frame_addr_in,
    input wire frame_io_in,
    input wire side_req_in,
    output reg frame_claim_out,
    output reg frame_abort_out,
    output reg side_accept_out,
    output wire stepping_out,
    output wire parity_report_out
);
    `include "bcl_map.vh"
    // ==============================================
    // register state
    reg [2:0] cmd_reg;
    reg [15:0] mem_base_reg;
    reg [15:0] mem_limit_reg;
    reg [15:0] pbase_reg;
    reg [15:0] plimit_reg;
    reg [7:0] io_base_reg;
    reg [7:0] io_limit_reg;
    reg [11:0] awaddr_reg;
    reg aw_held_reg;
    reg [31:0] wdata_reg;
    reg [3:0] wstrb_reg;
    reg w_held_reg;
    reg [7:0] claims_reg;
    reg [7:0] aborts_reg;
    wire [15:0] cmd_word;
    wire dec_hit;

    function [31:0] bcl_merge;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0] strb;
        integer i;
        begin
            for (i = 0; i < 4; i = i + 1) begin
                bcl_merge[i*8 +: 8] = strb[i] ? new_v[i*8 +: 8]
                                              : old_v[i*8 +: 8];
            end
        end
    endfunction

    function bcl_known;
        input [11:0] a;
        begin
            bcl_known = (a == `BCL_OFF_CMD) || (a == `BCL_OFF_MEMWIN) ||
                        (a == `BCL_OFF_PBASE) || (a == `BCL_OFF_IOWIN) ||
                        (a == `BCL_OFF_STAT);
        end
    endfunction

    // bits 15:8 and 7:3 read zero whatever is written
    assign cmd_word = {13'h0000, cmd_reg}; // RULE1 RULE2 RULE3 RULE4 RULE12
    assign stepping_out = 1'b0; // RULE1
    assign parity_report_out = 1'b0; // RULE2

    // ==============================================
    // write channel
    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
    wire aw_have = aw_held_reg || (s_axi_awvalid && s_axi_awready);
    wire w_have = w_held_reg || (s_axi_wvalid && s_axi_wready);
    wire [11:0] wa = aw_held_reg ? awaddr_reg : s_axi_awaddr;
    wire [31:0] wd = w_held_reg ? wdata_reg : s_axi_wdata;
    wire [3:0] ws = w_held_reg ? wstrb_reg : s_axi_wstrb;
    wire do_wr = aw_have && w_have && !s_axi_bvalid;
    wire [31:0] m_cmd = bcl_merge({16'h0000, cmd_word}, wd, ws);
    wire [31:0] m_mem = bcl_merge({mem_limit_reg, mem_base_reg}, wd, ws);
    wire [31:0] m_pre = bcl_merge({plimit_reg, pbase_reg}, wd, ws);
    wire [31:0] m_io = bcl_merge({16'h0000, io_limit_reg, io_base_reg},
                                 wd, ws);

    always @(posedge clk_in) begin
        if (srst_in) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= 12'h000;
            wdata_reg <= 32'h00000000;
            wstrb_reg <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `BCL_RESP_OK;
            cmd_reg <= `BCL_CMD_RST; // RULE5
            mem_base_reg <= `BCL_MEMBASE_RST;
            mem_limit_reg <= `BCL_MLIM_RST;
            pbase_reg <= `BCL_MEMBASE_RST;
            plimit_reg <= `BCL_MLIM_RST;
            io_base_reg <= `BCL_IO_BASE_RST;
            io_limit_reg <= `BCL_IOLIM_RST;
        end else begin
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (do_wr) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= bcl_known(wa) ? `BCL_RESP_OK : `BCL_RESP_ERR;
                case (wa)
                    `BCL_OFF_CMD: begin
                        // only the three enables are storage
                        cmd_reg <= m_cmd[2:0]; // RULE3 RULE4 RULE12
                    end
                    `BCL_OFF_MEMWIN: begin
                        mem_base_reg <= {m_mem[15:4], 4'h0};
                        mem_limit_reg <= {m_mem[31:20], 4'h0};
                    end
                    `BCL_OFF_PBASE: begin
                        pbase_reg <= {m_pre[15:4], 4'h0};
                        plimit_reg <= {m_pre[31:20], 4'h0};
                    end
                    `BCL_OFF_IOWIN: begin
                        io_base_reg <= {m_io[7:4], 4'h0};
                        io_limit_reg <= {m_io[15:12], 4'h0};
                    end
                    default: begin
                    end
                endcase
            end else begin
                if (s_axi_awvalid && s_axi_awready) begin
                    aw_held_reg <= 1'b1;
                    awaddr_reg <= s_axi_awaddr;
                end
                if (s_axi_wvalid && s_axi_wready) begin
                    w_held_reg <= 1'b1;
                    wdata_reg <= s_axi_wdata;
                    wstrb_reg <= s_axi_wstrb;
                end
            end
        end
    end

    // ==============================================
    // read channel
    assign s_axi_arready = !s_axi_rvalid;
    reg [31:0] rd_next;
    always @* begin
        case (s_axi_araddr)
            `BCL_OFF_CMD: rd_next = {16'h0000, cmd_word};
            `BCL_OFF_MEMWIN: rd_next = {mem_limit_reg, mem_base_reg};
            `BCL_OFF_PBASE: rd_next = {plimit_reg, pbase_reg};
            `BCL_OFF_IOWIN: rd_next = {16'h0000, io_limit_reg, io_base_reg};
            `BCL_OFF_STAT: rd_next = {16'h0000, aborts_reg, claims_reg};
            default: rd_next = 32'h00000000;
        endcase
    end

    always @(posedge clk_in) begin
        if (srst_in) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `BCL_RESP_OK;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_next;
            s_axi_rresp <= bcl_known(s_axi_araddr) ? `BCL_RESP_OK
                                                   : `BCL_RESP_ERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ==============================================
    // secondary cycle gating
    bcl_decode u_dec (
        .mem_en_in(cmd_reg[`BCL_BIT_MEM]),
        .io_en_in(cmd_reg[`BCL_BIT_IO]),
        .addr_in(frame_addr_in),
        .is_io_in(frame_io_in),
        .mem_base_in(mem_base_reg),
        .mem_limit_in(mem_limit_reg),
        .pbase_in(pbase_reg),
        .plimit_in(plimit_reg),
        .io_base_in(io_base_reg),
        .io_limit_in(io_limit_reg),
        .hit_out(dec_hit)
    );

    wire claim_now = frame_req_in && cmd_reg[`BCL_BIT_MST] && dec_hit;

    // counters saturate so a busy bus cannot wrap them back to zero
    always @(posedge clk_in) begin
        if (srst_in) begin
            frame_claim_out <= 1'b0;
            frame_abort_out <= 1'b0;
            side_accept_out <= 1'b0;
            claims_reg <= 8'h00;
            aborts_reg <= 8'h00;
        end else begin
            frame_claim_out <= claim_now; // RULE6
            frame_abort_out <= frame_req_in && !claim_now; // RULE5
            side_accept_out <= side_req_in; // RULE7
            if (claim_now && claims_reg != 8'hff) begin
                claims_reg <= claims_reg + 8'h01;
            end
            if (frame_req_in && !claim_now && aborts_reg != 8'hff) begin
                aborts_reg <= aborts_reg + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// File: bcl_checker.sv
// checker for bcl_top: axi answers, frame gating, hardwired outputs
// assumes one clock and srst_in synchronous, active high
`timescale 1ns/1ps
`default_nettype none
`include "bcl_map.vh"
module bcl_checker (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic frame_req_in,
    input wire logic frame_claim_out,
    input wire logic frame_abort_out,
    input wire logic side_req_in,
    input wire logic side_accept_out,
    input wire logic stepping_out,
    input wire logic parity_report_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);
    // which register the pending read answer belongs to
    logic [11:0] rd_addr_reg;
    always @(posedge clk_in) begin
        if (s_axi_arvalid && s_axi_arready) rd_addr_reg <= s_axi_araddr;
    end
    a_step_low: assert property (!stepping_out)
        else $error("stepping set");
    a_parity_low: assert property (!parity_report_out)
        else $error("parity report set");
    a_frame_answer: assert property (frame_req_in |=>
        frame_claim_out != frame_abort_out) else $error("no single answer");
    a_side_free: assert property (side_req_in |=> side_accept_out)
        else $error("side request dropped");
    a_cmd_fixed: assert property (
        s_axi_rvalid && rd_addr_reg == `BCL_OFF_CMD |->
        s_axi_rdata[31:3] == 29'h0) else $error("fixed command bits set");
    a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid) else $error("read answer late");
    a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
    a_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write resp moved");
    c_claim: cover property (frame_claim_out);
    c_abort: cover property (frame_abort_out);
    c_side: cover property (side_accept_out && frame_abort_out);
endmodule
bind bcl_top bcl_checker chk_i (.*);
`default_nettype wire

// File: bcl_agp_model.sv
// secondary bus master model: one frame cycle at a time, side requests
// assumes claim and abort answer one clock after the request clock
`timescale 1ns/1ps
`default_nettype none
module bcl_agp_model (
    input wire logic clk_in,
    input wire logic claim_in,
    input wire logic abort_in,
    input wire logic side_ack_in,
    output logic frame_req_out,
    output logic [31:0] frame_addr_out,
    output logic frame_io_out,
    output logic side_req_out
);
    initial begin
        frame_req_out = 1'b0;
        frame_addr_out = 32'h0;
        frame_io_out = 1'b0;
        side_req_out = 1'b0;
    end
    task automatic run(input logic [31:0] a, input logic io, input logic sd,
        output logic [2:0] seen);
        @(posedge clk_in);
        frame_req_out <= 1'b1;
        frame_addr_out <= a;
        frame_io_out <= io;
        side_req_out <= sd;
        @(posedge clk_in);
        frame_req_out <= 1'b0;
        // released lines invert so a stale address can never match
        frame_addr_out <= ~a;
        frame_io_out <= ~io;
        side_req_out <= 1'b0;
        #1 seen = {side_ack_in, abort_in, claim_in};
    endtask
endmodule
`default_nettype wire

// File: tb.sv
// self-checking bench for bcl_top: registers and frame gating
// assumes bcl_agp_model stands in for the secondary master
`timescale 1ns/1ps
`default_nettype none
`include "bcl_map.vh"
module tb;
    logic clk_in = 1'b0, srst_in = 1'b1;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire s_axi_rvalid, frame_claim_out, frame_abort_out, side_accept_out;
    wire frame_req_in, frame_io_in, side_req_in, stepping_out;
    wire parity_report_out;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata, frame_addr_in;
    int err_count = 0, checks = 0;
    always #5 clk_in = ~clk_in;
    bcl_top uut (.*);
    bcl_agp_model agp (.clk_in(clk_in), .claim_in(frame_claim_out),
        .abort_in(frame_abort_out), .side_ack_in(side_accept_out),
        .frame_req_out(frame_req_in), .frame_addr_out(frame_addr_in),
        .frame_io_out(frame_io_in), .side_req_out(side_req_in));
    task automatic chk(input string nm, input logic [31:0] sn, exp);
        checks++;
        if (sn !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, sn);
        end
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // one write or one read; for a read d is the expected data
    task automatic axi(input logic wr, input logic [11:0] a,
        input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
        logic done;
        done = 1'b0;
        @(posedge clk_in);
        if (wr) begin
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_wstrb <= s;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
        end else begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
        end
        for (int n = 0; n < 20 && !done; n++) begin
            @(posedge clk_in);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (wr && s_axi_bvalid === 1'b1) begin
                done = 1'b1;
                s_axi_bready <= 1'b0;
                chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
            end
            if (!wr && s_axi_rvalid === 1'b1) begin
                done = 1'b1;
                s_axi_rready <= 1'b0;
                chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
                chk("rdata", s_axi_rdata, d);
            end
        end
        chk("answer", {31'h0, done}, 32'h1);
    endtask
    // {command, io cycle, claim expected, address}
    function automatic logic [36:0] ent(input int i);
        case (i)
            0: ent = {3'h4, 1'b0, 1'b0, 32'h00100000};
            1: ent = {3'h6, 1'b0, 1'b1, 32'h00100000};
            2: ent = {3'h6, 1'b0, 1'b1, 32'h001fffff};
            3: ent = {3'h6, 1'b0, 1'b1, 32'h003fffff};
            4: ent = {3'h6, 1'b0, 1'b0, 32'h00400000};
            5: ent = {3'h6, 1'b0, 1'b1, 32'h000a0000};
            6: ent = {3'h6, 1'b0, 1'b0, 32'h000c0000};
            7: ent = {3'h2, 1'b0, 1'b0, 32'h00100000};
            8: ent = {3'h6, 1'b1, 1'b0, 32'h00002000};
            9: ent = {3'h5, 1'b1, 1'b1, 32'h00003fff};
            10: ent = {3'h5, 1'b1, 1'b0, 32'h00001fff};
            11: ent = {3'h5, 1'b0, 1'b0, 32'h00100000};
            default: ent = 37'h0;
        endcase
    endfunction
    task automatic fr(input int i);
        logic [36:0] e;
        logic [2:0] seen;
        e = ent(i);
        axi(1'b1, `BCL_OFF_CMD, {29'h0, e[36:34]}, 4'hf, `BCL_RESP_OK);
        agp.run(e[31:0], e[33], i[0], seen);
        chk("frame", {29'h0, seen}, {29'h0, i[0], !e[32], e[32]});
    endtask
    task automatic t_reset();
        axi(1'b0, `BCL_OFF_CMD, 32'h0, 4'h0, `BCL_RESP_OK);
        axi(1'b0, `BCL_OFF_IOWIN, 32'h000000f0, 4'h0, `BCL_RESP_OK);
        axi(1'b0, `BCL_OFF_MEMWIN, 32'h0000fff0, 4'h0, `BCL_RESP_OK);
        axi(1'b0, `BCL_OFF_PBASE, 32'h0000fff0, 4'h0, `BCL_RESP_OK);
        axi(1'b0, `BCL_OFF_STAT, 32'h0, 4'h0, `BCL_RESP_OK);
    endtask
    task automatic t_fixed();
        axi(1'b1, `BCL_OFF_CMD, 32'hffffffff, 4'hf, `BCL_RESP_OK);
        chk("stepping", {31'h0, stepping_out}, 32'h0);
        chk("parity", {31'h0, parity_report_out}, 32'h0);
        axi(1'b0, `BCL_OFF_CMD, 32'h7, 4'h0, `BCL_RESP_OK);
        axi(1'b1, `BCL_OFF_CMD, 32'h0, 4'h0, `BCL_RESP_OK);
        axi(1'b0, `BCL_OFF_CMD, 32'h7, 4'h0, `BCL_RESP_OK);
        axi(1'b1, 12'h100, 32'h0, 4'hf, `BCL_RESP_ERR);
        axi(1'b0, 12'h100, 32'h0, 4'h0, `BCL_RESP_ERR);
    endtask
    task automatic t_windows();
        axi(1'b1, `BCL_OFF_MEMWIN, 32'h00100010, 4'hf, `BCL_RESP_OK);
        axi(1'b1, `BCL_OFF_PBASE, 32'h00300020, 4'hf, `BCL_RESP_OK);
        axi(1'b1, `BCL_OFF_IOWIN, 32'h00003020, 4'hf, `BCL_RESP_OK);
        for (int i = 0; i < 12; i++) fr(i);
        // five claimed and seven ignored cycles in the table above
        axi(1'b0, `BCL_OFF_STAT, 32'h00000705, 4'h0, `BCL_RESP_OK);
    endtask
    initial begin
        repeat (6) @(posedge clk_in);
        srst_in <= 1'b0;
        t_reset();
        t_fixed();
        t_windows();
        close_out();
    end
    initial begin
        repeat (5000) @(posedge clk_in);
        err_count++;
        close_out();
    end
endmodule
`default_nettype wire
